// >>> rtl/usb_endpoint_dma_stall_ctrl.sv
// usb function control: bulk-out dma request, forced endpoint stall, phy select.
// assumes the usb packet engine presents tokens and received bytes on this clock,
// and the system dma controller reads one byte per dual-address cycle.
//
// How it works
// - dma request is high while dma enabled and the fifo holds a byte
// - last byte of a packet read by dma completes the read automatically
// - dma enable never masks the bulk-out interrupt request
// - non-setup token to a stalled endpoint gets a stall handshake
// - endpoint 0 stall clears on a decoded 8-byte setup command
// - writing 1 to endpoint 0 stall is ignored while setup flag set
// - stall bits for endpoints 3..0 in bits 3..0, reset to 0
// - unused upper bits read 0; writes to them are dropped
// - phy select 1 stops internal phy and routes external pins
// - read completion flushes the fifo just read
// - each dma cycle moves exactly one byte
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_dma_stall_ctrl
    import usb_ep_ctrl_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    // avalon-mm slave
    input wire logic [3:0] I_AVM_ADDRESS,
    input wire logic I_AVM_READ,
    input wire logic I_AVM_WRITE,
    input wire logic [31:0] I_AVM_WRITEDATA,
    input wire logic [3:0] I_AVM_BYTEENABLE,
    output logic [31:0] O_AVM_READDATA,
    output logic O_AVM_WAITREQUEST,
    // packet engine side
    input wire logic I_TOKEN_VALID,
    input wire logic [1:0] I_TOKEN_EP,
    input wire logic I_TOKEN_SETUP,
    input wire logic I_SETUP_DECODED,
    input wire logic I_SETUP_PACKET_RECEIVED_FLAG,
    input wire logic I_RX_VALID,
    input wire logic [7:0] I_RX_DATA,
    input wire logic I_RX_PKT_END,
    output logic O_RX_READY,
    output logic O_STALL_HANDSHAKE,
    output logic O_BULK_OUT_IRQ_REQ,
    // system dma controller
    output logic O_DMA_REQ,
    input wire logic I_DMA_ACK,
    output logic [7:0] O_DMA_DATA,
    // software read-done trigger from the trigger register block
    input wire logic I_BULK_OUT_READ_DONE_TRIGGER,
    // transceiver
    output logic O_INTERNAL_PHY_ENABLE,
    output logic O_EXTERNAL_PHY_SELECT
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ACK = 3'b010,
        BUS_DONE = 3'b100
    } bus_e;

    typedef struct packed {
        bus_e bus;
        logic [31:0] rdata;
        logic [1:0] dma_setting;
        logic [NUM_EP-1:0] stall;
        logic phy_sel;
        logic [4:0] pkt_left;
        logic pkt_open;
        logic auto_done;
        logic stall_hs;
        logic [7:0] dma_data;
        logic setup_sync1;
        logic setup_sync2;
    } ctrl_state_s;

    ctrl_state_s st_q;
    ctrl_state_s st_d;

    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic [4:0] fifo_count;
    logic fifo_flush;
    logic dma_pop;
    logic rx_push;
    logic wr_hit;
    logic rd_hit;
    logic [3:0] wr_stall;

    // ------------------------------------------------------------------
    // receive fifo
    // ------------------------------------------------------------------
    usb_rx_fifo #(
        .WIDTH(RX_WIDTH),
        .DEPTH(RX_DEPTH),
        .AW(RX_AW)
    ) u_rx_fifo (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_flush(fifo_flush),
        .i_in_valid(I_RX_VALID),
        .o_in_ready(fifo_in_ready),
        .i_in_data(I_RX_DATA),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(dma_pop),
        .o_out_data(fifo_out_data),
        .o_count(fifo_count)
    );

    // ------------------------------------------------------------------
    // combinational helpers
    // ------------------------------------------------------------------
    // the fifo stalls the packet engine when full; it must then nack the host
    assign O_RX_READY = fifo_in_ready;
    assign rx_push = I_RX_VALID && fifo_in_ready;
    // one byte leaves per acknowledged dma cycle
    assign dma_pop = I_DMA_ACK && O_DMA_REQ && st_q.dma_setting[BIT_BULK_OUT_DMA_ENABLE];
    // software trigger or the automatic completion both empty the fifo
    assign fifo_flush = I_BULK_OUT_READ_DONE_TRIGGER || st_q.auto_done;
    // a write lands only on the edge where the master sees waitrequest low
    assign wr_hit = (st_q.bus == BUS_DONE) && I_AVM_WRITE && I_AVM_BYTEENABLE[0];
    assign rd_hit = (st_q.bus == BUS_IDLE) && I_AVM_READ;
    assign wr_stall = I_AVM_WRITEDATA[3:0];

    always_comb begin
        st_d = st_q;
        st_d.auto_done = 1'b0;
        st_d.stall_hs = 1'b0;
        st_d.setup_sync1 = I_SETUP_PACKET_RECEIVED_FLAG;
        st_d.setup_sync2 = st_q.setup_sync1;

        // --------------------------------------------------------------
        // avalon-mm slave: two wait cycles, then the answer
        // --------------------------------------------------------------
        case (st_q.bus)
            BUS_IDLE: begin
                if (I_AVM_READ || I_AVM_WRITE) begin
                    st_d.bus = BUS_ACK;
                end
            end
            BUS_ACK: begin
                st_d.bus = BUS_DONE;
            end
            BUS_DONE: begin
                st_d.bus = BUS_IDLE;
            end
            default: begin
                st_d.bus = BUS_IDLE;
            end
        endcase

        if (wr_hit) begin
            case (I_AVM_ADDRESS)
                OFS_DMA_TRANSFER_SETTING: begin
                    st_d.dma_setting = I_AVM_WRITEDATA[1:0];
                end
                OFS_ENDPOINT_STALL_CONTROL: begin
                    st_d.stall = wr_stall;
                    // setting endpoint 0 stall is refused during a pending setup
                    if (st_q.setup_sync2 && wr_stall[0] && !st_q.stall[0]) begin
                        st_d.stall[0] = 1'b0;
                    end
                end
                OFS_TRANSCEIVER_SELECT: begin
                    st_d.phy_sel = I_AVM_WRITEDATA[BIT_EXTERNAL_PHY_SELECT];
                end
                default: begin
                end
            endcase
        end

        if (rd_hit) begin
            case (I_AVM_ADDRESS)
                OFS_DMA_TRANSFER_SETTING: st_d.rdata = {30'h0000_0000, st_q.dma_setting};
                OFS_ENDPOINT_STALL_CONTROL: st_d.rdata = {28'h000_0000, st_q.stall};
                OFS_TRANSCEIVER_SELECT: st_d.rdata = {31'h0000_0000, st_q.phy_sel};
                OFS_BULK_OUT_STATUS: st_d.rdata = {27'h000_0000, fifo_count};
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end

        // --------------------------------------------------------------
        // decoded setup command releases endpoint 0; wins over a write
        // --------------------------------------------------------------
        if (I_TOKEN_VALID && I_TOKEN_SETUP && I_SETUP_DECODED && I_TOKEN_EP == 2'h0) begin
            st_d.stall[0] = 1'b0;
        end

        // stall handshake for any non-setup token to a stalled endpoint
        if (I_TOKEN_VALID && !I_TOKEN_SETUP && st_q.stall[I_TOKEN_EP]) begin
            st_d.stall_hs = 1'b1;
        end

        // --------------------------------------------------------------
        // packet byte tracking for automatic completion
        // --------------------------------------------------------------
        if (fifo_flush) begin
            st_d.pkt_left = RX_CNT_ZERO;
            st_d.pkt_open = 1'b0;
        end else begin
            st_d.pkt_left = st_q.pkt_left + 5'(rx_push) - 5'(dma_pop);
            // last byte of a closed packet drained by dma
            if (st_q.pkt_open && dma_pop && st_q.pkt_left == 5'h01 && !rx_push) begin
                st_d.auto_done = 1'b1;
                st_d.pkt_open = 1'b0;
            end
            // a packet end in the same cycle wins over the completion clear
            if (I_RX_PKT_END) begin
                st_d.pkt_open = 1'b1;
            end
        end

        if (dma_pop) begin
            st_d.dma_data = fifo_out_data;
        end
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            st_q <= '0;
            st_q.bus <= BUS_IDLE;
            st_q.dma_setting <= RST_DMA_TRANSFER_SETTING;
            st_q.stall <= RST_ENDPOINT_STALL_CONTROL;
            st_q.phy_sel <= RST_TRANSCEIVER_SELECT;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign O_AVM_WAITREQUEST = (st_q.bus != BUS_DONE);
    assign O_AVM_READDATA = st_q.rdata;
    // request follows the fifo level and the enable directly
    assign O_DMA_REQ = st_q.dma_setting[BIT_BULK_OUT_DMA_ENABLE] && fifo_out_valid;
    assign O_DMA_DATA = st_q.dma_data;
    // interrupt request independent of the dma enable
    assign O_BULK_OUT_IRQ_REQ = st_q.pkt_open;
    assign O_STALL_HANDSHAKE = st_q.stall_hs;
    assign O_EXTERNAL_PHY_SELECT = st_q.phy_sel;
    assign O_INTERNAL_PHY_ENABLE = !st_q.phy_sel;
endmodule : usb_endpoint_dma_stall_ctrl
`default_nettype wire

// >>> rtl/usb_ep_ctrl_pkg.sv
// package: register map, field positions, reset values and fifo sizing for the
// usb endpoint dma / stall / transceiver-select control block.
// assumes a 32-bit avalon-mm register bus with byte addresses.
package usb_ep_ctrl_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_DMA_TRANSFER_SETTING = 4'h0;
    localparam logic [3:0] OFS_ENDPOINT_STALL_CONTROL = 4'h4;
    localparam logic [3:0] OFS_TRANSCEIVER_SELECT = 4'h8;
    localparam logic [3:0] OFS_BULK_OUT_STATUS = 4'hc;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int BIT_BULK_OUT_DMA_ENABLE = 0;
    localparam int BIT_BULK_IN_DMA_ENABLE = 1;
    localparam int BIT_EXTERNAL_PHY_SELECT = 0;
    localparam int NUM_EP = 4;
    localparam logic [1:0] RST_DMA_TRANSFER_SETTING = 2'h0;
    localparam logic [3:0] RST_ENDPOINT_STALL_CONTROL = 4'h0;
    localparam logic RST_TRANSCEIVER_SELECT = 1'b0;

    // ------------------------------------------------------------------
    // receive fifo sizing (bytes, one byte per dma cycle)
    // ------------------------------------------------------------------
    localparam int RX_WIDTH = 8;
    localparam int RX_DEPTH = 16;
    localparam int RX_AW = 4;
    localparam logic [4:0] RX_CNT_ZERO = 5'h00;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avmm_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avmm_rsp_s;

    typedef struct packed {
        logic [1:0] ep;
        logic setup;
        logic valid;
    } usb_token_s;
endpackage : usb_ep_ctrl_pkg

// >>> rtl/usb_rx_fifo.sv
// byte fifo between the usb receive path and the dma read port.
// assumes writer and reader share one clock; flush empties it in one cycle.
`timescale 1ns/1ps
`default_nettype none
module usb_rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [AW:0] o_count
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_state_s;

    fifo_state_s st_q;
    fifo_state_s st_d;
    logic push;
    logic pop;

    // depth needs the extra count bit: a cast to AW bits would wrap it to zero
    assign o_in_ready = (st_q.cnt != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign o_out_valid = (st_q.cnt != '0);
    assign o_out_data = st_q.mem[st_q.rp];
    assign o_count = st_q.cnt;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wp] = i_in_data;
            st_d.wp = st_q.wp + AW'(1);
        end
        if (pop) begin
            st_d.rp = st_q.rp + AW'(1);
        end
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (i_flush) begin
            st_d.wp = '0;
            st_d.rp = '0;
            st_d.cnt = '0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : usb_rx_fifo
`default_nettype wire

// >>> tb/usb_ep_ctrl_props.sv
// checker: bus answer timing, stall pulse, phy select and fifo level relations
// assumes it is bound to the control block top and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module usb_ep_ctrl_props (
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_AVM_READ,
    input wire logic I_AVM_WRITE,
    input wire logic O_AVM_WAITREQUEST,
    input wire logic I_TOKEN_VALID,
    input wire logic I_TOKEN_SETUP,
    input wire logic I_RX_VALID,
    input wire logic I_RX_PKT_END,
    input wire logic O_RX_READY,
    input wire logic O_STALL_HANDSHAKE,
    input wire logic O_BULK_OUT_IRQ_REQ,
    input wire logic O_DMA_REQ,
    input wire logic I_DMA_ACK,
    input wire logic I_BULK_OUT_READ_DONE_TRIGGER,
    input wire logic O_INTERNAL_PHY_ENABLE,
    input wire logic O_EXTERNAL_PHY_SELECT
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    // ------------------------------------------------------------------
    // byte level seen from the ports, so no view inside the fifo is needed
    // ------------------------------------------------------------------
    logic [4:0] lvl_q;
    logic [4:0] lvl_d;
    always_comb begin
        lvl_d = lvl_q + 5'(I_RX_VALID && O_RX_READY) - 5'(O_DMA_REQ && I_DMA_ACK);
        if (I_BULK_OUT_READ_DONE_TRIGGER) begin
            lvl_d = 5'h00;
        end
    end
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            lvl_q <= 5'h00;
        end else begin
            lvl_q <= lvl_d;
        end
    end
    property p_ans;
        $rose(I_AVM_READ || I_AVM_WRITE) |-> O_AVM_WAITREQUEST ##1 O_AVM_WAITREQUEST
            ##1 !O_AVM_WAITREQUEST;
    endproperty
    a_ans: assert property (p_ans) else $error("bus answer not in third cycle");
    property p_idle;
        !(I_AVM_READ || I_AVM_WRITE) |-> O_AVM_WAITREQUEST;
    endproperty
    a_idle: assert property (p_idle) else $error("waitrequest low while idle");
    property p_phy;
        O_INTERNAL_PHY_ENABLE != O_EXTERNAL_PHY_SELECT;
    endproperty
    a_phy: assert property (p_phy) else $error("phy enable and select agree");
    property p_setup;
        I_TOKEN_VALID && I_TOKEN_SETUP |=> !O_STALL_HANDSHAKE;
    endproperty
    a_setup: assert property (p_setup) else $error("stall on setup token");
    property p_notok;
        !I_TOKEN_VALID |=> !O_STALL_HANDSHAKE;
    endproperty
    a_notok: assert property (p_notok) else $error("stall without token");
    property p_empty;
        lvl_q == 5'h00 |-> !O_DMA_REQ;
    endproperty
    a_empty: assert property (p_empty) else $error("dma request with fifo empty");
    property p_full;
        lvl_q == 5'h10 |-> !O_RX_READY;
    endproperty
    a_full: assert property (p_full) else $error("ready while fifo full");
    property p_room;
        lvl_q < 5'h10 |-> O_RX_READY;
    endproperty
    a_room: assert property (p_room) else $error("not ready with room left");
    property p_irq;
        I_RX_PKT_END && lvl_q != 5'h00 && !I_DMA_ACK |=> O_BULK_OUT_IRQ_REQ;
    endproperty
    a_irq: assert property (p_irq) else $error("packet interrupt missing");
    c_stall: cover property (O_STALL_HANDSHAKE);
    c_full: cover property (lvl_q == 5'h10);
    c_pop: cover property (O_DMA_REQ && I_DMA_ACK);
endmodule : usb_ep_ctrl_props
bind usb_endpoint_dma_stall_ctrl usb_ep_ctrl_props u_props (.I_CLK_SYS, .I_RST, .I_AVM_READ,
    .I_AVM_WRITE, .O_AVM_WAITREQUEST, .I_TOKEN_VALID, .I_TOKEN_SETUP, .I_RX_VALID, .I_RX_PKT_END,
    .O_RX_READY, .O_STALL_HANDSHAKE, .O_BULK_OUT_IRQ_REQ, .O_DMA_REQ, .I_DMA_ACK,
    .I_BULK_OUT_READ_DONE_TRIGGER, .O_INTERNAL_PHY_ENABLE, .O_EXTERNAL_PHY_SELECT);
`default_nettype wire

// >>> tb/dma_ctrl_model.sv
// model of the system dma controller draining the bulk-out fifo
// assumes request and byte as the control block presents them
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic i_slow,
    input wire logic i_req,
    input wire logic [7:0] i_data,
    output logic o_ack,
    output logic [4:0] o_n
);
    logic pend_q;
    logic [7:0] log_q [16];
    // ------------------------------------------------------------------
    // one byte per acknowledged request; slow mode acks every other cycle
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ack <= 1'b0;
            pend_q <= 1'b0;
            o_n <= 5'h00;
        end else begin
            o_ack <= i_go && !(i_slow && o_ack);
            pend_q <= i_req && o_ack;
            if (pend_q) begin
                log_q[o_n[3:0]] <= i_data;
                o_n <= o_n + 5'h01;
            end
        end
    end
endmodule : dma_ctrl_model
`default_nettype wire

// >>> tb/tb_top.sv
// testbench: registers, forced stall, setup handling, bulk-out dma drain, flush
// assumes the control block with its fifo, the dma model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import usb_ep_ctrl_pkg::*;
    logic I_CLK_SYS = 0, I_RST = 1, I_AVM_READ = 0, I_AVM_WRITE = 0;
    logic [3:0] I_AVM_ADDRESS = 0, I_AVM_BYTEENABLE = 0;
    logic [31:0] I_AVM_WRITEDATA = 0, O_AVM_READDATA;
    logic O_AVM_WAITREQUEST, O_RX_READY, O_STALL_HANDSHAKE, O_BULK_OUT_IRQ_REQ, O_DMA_REQ;
    logic I_TOKEN_VALID = 0, I_TOKEN_SETUP = 0, I_SETUP_DECODED = 0, I_RX_VALID = 0;
    logic I_RX_PKT_END = 0, I_SETUP_PACKET_RECEIVED_FLAG = 0, I_BULK_OUT_READ_DONE_TRIGGER = 0;
    logic [1:0] I_TOKEN_EP = 0;
    logic [7:0] I_RX_DATA = 0, O_DMA_DATA;
    logic I_DMA_ACK, O_INTERNAL_PHY_ENABLE, O_EXTERNAL_PHY_SELECT, go = 0, slow = 0;
    logic [4:0] n_got;
    int num_errors = 0, num_checks = 0, cyc = 0;
    usb_endpoint_dma_stall_ctrl dut (.I_CLK_SYS, .I_RST, .I_AVM_ADDRESS, .I_AVM_READ, .I_AVM_WRITE,
        .I_AVM_WRITEDATA, .I_AVM_BYTEENABLE, .O_AVM_READDATA, .O_AVM_WAITREQUEST, .I_TOKEN_VALID,
        .I_TOKEN_EP, .I_TOKEN_SETUP, .I_SETUP_DECODED, .I_SETUP_PACKET_RECEIVED_FLAG, .I_RX_VALID,
        .I_RX_DATA, .I_RX_PKT_END, .O_RX_READY, .O_STALL_HANDSHAKE, .O_BULK_OUT_IRQ_REQ, .O_DMA_REQ,
        .I_DMA_ACK, .O_DMA_DATA, .I_BULK_OUT_READ_DONE_TRIGGER, .O_INTERNAL_PHY_ENABLE,
        .O_EXTERNAL_PHY_SELECT);
    dma_ctrl_model dma (.i_clk(I_CLK_SYS), .i_rst(I_RST), .i_go(go), .i_slow(slow),
        .i_req(O_DMA_REQ), .i_data(O_DMA_DATA), .o_ack(I_DMA_ACK), .o_n(n_got));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge I_CLK_SYS);
        I_AVM_ADDRESS <= a;
        I_AVM_WRITE <= wr;
        I_AVM_READ <= !wr;
        I_AVM_WRITEDATA <= d;
        I_AVM_BYTEENABLE <= be;
        do @(posedge I_CLK_SYS); while (O_AVM_WAITREQUEST !== 1'b0);
        q = O_AVM_READDATA;
        I_AVM_READ <= 1'b0;
        I_AVM_WRITE <= 1'b0;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask : wr
    task automatic rdc(input string w, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, 4'hf, q);
        chk(w, e, q);
    endtask : rdc
    task automatic tok(input logic [1:0] ep, input logic st, input logic e);
        @(posedge I_CLK_SYS);
        I_TOKEN_VALID <= 1'b1;
        I_TOKEN_EP <= ep;
        I_TOKEN_SETUP <= st;
        I_SETUP_DECODED <= st;
        @(posedge I_CLK_SYS);
        I_TOKEN_VALID <= 1'b0;
        I_TOKEN_SETUP <= 1'b0;
        I_SETUP_DECODED <= 1'b0;
        @(posedge I_CLK_SYS);
        chk("stall handshake", 32'(e), 32'(O_STALL_HANDSHAKE));
    endtask : tok
    task automatic push(input int n, input logic en);
        @(posedge I_CLK_SYS);
        for (int i = 0; i < n; i++) begin
            I_RX_VALID <= 1'b1;
            I_RX_DATA <= 8'h a0 + 8'(i);
            do @(posedge I_CLK_SYS); while (O_RX_READY !== 1'b1);
        end
        I_RX_VALID <= 1'b0;
        I_RX_PKT_END <= en;
        @(posedge I_CLK_SYS);
        I_RX_PKT_END <= 1'b0;
    endtask : push
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        rdc("stall reset", OFS_ENDPOINT_STALL_CONTROL, 32'h0000_0000);
        rdc("phy reset", OFS_TRANSCEIVER_SELECT, 32'h0000_0000);
        rdc("dma reset", OFS_DMA_TRANSFER_SETTING, 32'h0000_0000);
        rdc("unmapped", 4'h2, 32'h0000_0000);
        wr(OFS_ENDPOINT_STALL_CONTROL, 32'h0000_00ff);
        wr(OFS_ENDPOINT_STALL_CONTROL, 32'h0000_0000, 4'h0);
        rdc("stall bits", OFS_ENDPOINT_STALL_CONTROL, 32'h0000_000f);
        wr(OFS_ENDPOINT_STALL_CONTROL, 32'h0000_0000);
        for (int v = 0; v < 2; v++) begin
            wr(OFS_TRANSCEIVER_SELECT, v ? 32'h0000_00ff : 32'h0000_0000);
            rdc("phy select", OFS_TRANSCEIVER_SELECT, 32'(v));
            repeat (2) @(posedge I_CLK_SYS);
            chk("external phy", 32'(v), 32'(O_EXTERNAL_PHY_SELECT));
            chk("internal phy", 32'(!v), 32'(O_INTERNAL_PHY_ENABLE));
        end
        wr(OFS_TRANSCEIVER_SELECT, 32'h0000_0000);
    endtask : t_regs
    task automatic t_stall();
        for (int s = 0; s < 4; s++) begin
            wr(OFS_ENDPOINT_STALL_CONTROL, 32'h1 << s);
            for (int e = 0; e < 4; e++) begin
                tok(2'(e), 1'b0, e == s);
            end
        end
        wr(OFS_ENDPOINT_STALL_CONTROL, 32'h0000_0001);
        tok(2'h0, 1'b1, 1'b0);
        rdc("stall after setup", OFS_ENDPOINT_STALL_CONTROL, 32'h0000_0000);
        for (int f = 1; f >= 0; f--) begin
            I_SETUP_PACKET_RECEIVED_FLAG <= f[0];
            repeat (4) @(posedge I_CLK_SYS);
            wr(OFS_ENDPOINT_STALL_CONTROL, 32'h0000_0001);
            rdc("stall under flag", OFS_ENDPOINT_STALL_CONTROL, 32'(!f));
        end
        wr(OFS_ENDPOINT_STALL_CONTROL, 32'h0000_0000);
    endtask : t_stall
    task automatic t_dma();
        wr(OFS_DMA_TRANSFER_SETTING, 32'h0000_0001);
        push(16, 1'b1);
        chk("rx ready full", 32'h0, 32'(O_RX_READY));
        rdc("fifo count", OFS_BULK_OUT_STATUS, 32'h0000_0010);
        chk("dma request", 32'h1, 32'(O_DMA_REQ));
        chk("packet irq", 32'h1, 32'(O_BULK_OUT_IRQ_REQ));
        slow <= 1'b1;
        go <= 1'b1;
        while (n_got !== 5'h10) @(posedge I_CLK_SYS);
        for (int i = 0; i < 16; i++) begin
            chk("dma byte", 32'(8'ha0 + 8'(i)), 32'(dma.log_q[i]));
        end
        repeat (2) @(posedge I_CLK_SYS);
        chk("request dropped", 32'h0, 32'(O_DMA_REQ));
        rdc("auto completion", OFS_BULK_OUT_STATUS, 32'h0000_0000);
        chk("packet closed", 32'h0, 32'(O_BULK_OUT_IRQ_REQ));
        go <= 1'b0;
    endtask : t_dma
    task automatic t_flush();
        wr(OFS_DMA_TRANSFER_SETTING, 32'h0000_0000);
        push(3, 1'b0);
        chk("request disabled", 32'h0, 32'(O_DMA_REQ));
        rdc("fifo count", OFS_BULK_OUT_STATUS, 32'h0000_0003);
        @(posedge I_CLK_SYS);
        I_BULK_OUT_READ_DONE_TRIGGER <= 1'b1;
        @(posedge I_CLK_SYS);
        I_BULK_OUT_READ_DONE_TRIGGER <= 1'b0;
        rdc("flushed", OFS_BULK_OUT_STATUS, 32'h0000_0000);
    endtask : t_flush
    initial begin
        forever #4 I_CLK_SYS = ~I_CLK_SYS;
    end
    // the whole sequence needs well under 3000 cycles
    always @(posedge I_CLK_SYS) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge I_CLK_SYS);
        I_RST <= 1'b0;
        t_regs();
        t_stall();
        t_dma();
        t_flush();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
